// ==== pkg/ccp_pkg.sv ====
// package for the CAN controller power, interrupt and bus-off control block
// assumes a classic Wishbone slave with 32-bit data and byte addresses
package ccp_pkg;
    localparam logic [7:0] CTRL0_ADDR = 8'h00;
    localparam logic [7:0] CTRL1_ADDR = 8'h04;
    localparam logic [7:0] RFLG_ADDR  = 8'h08;
    localparam logic [7:0] RIER_ADDR  = 8'h0C;
    localparam logic [7:0] TFLG_ADDR  = 8'h10;
    localparam logic [7:0] TIER_ADDR  = 8'h14;
    localparam logic [7:0] MISC_ADDR  = 8'h18;
    localparam logic [7:0] STAT_ADDR  = 8'h1C;
    // control_reg_zero fields
    localparam int C0_WUPEN = 2;
    localparam int C0_SLEEP_REQUEST = 1;
    localparam int C0_INIRQ = 0;
    // control_reg_one fields
    localparam int C1_ENABLE = 7;
    localparam int C1_BORUM  = 3;
    localparam int C1_WFILT  = 2;
    localparam int C1_SLEEP_ACKNOWLEDGE  = 1;
    localparam int C1_INIAK  = 0;
    // receiver_flag_reg fields
    localparam int RF_WAKE = 7;
    localparam int RF_CSC  = 6;
    localparam int RF_RST  = 4;
    localparam int RF_TST  = 2;
    localparam int RF_OVR  = 1;
    localparam int RF_RXF  = 0;
    localparam logic [7:0] CTRL0_RST = 8'h01;
    localparam logic [7:0] CTRL1_RST = 8'h01;
    localparam logic [7:0] MISC_RST  = 8'h00;
    localparam logic [2:0] TXE_RST   = 3'h7;
    // bus-off recovery: 128 runs of 11 recessive bits
    localparam int RECESSIVE_RUN = 11;
    localparam int RECOVERY_RUNS = 128;
    // wake-up glitch filter, least time in ns
    localparam int WAKE_FILTER_NS  = 500;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bit time in system clocks, plain default
    localparam int BIT_CYC = 40;
    localparam int INIT_SYNC_CYC = 3;

    typedef enum logic [1:0] {CCP_OK, CCP_WARN, CCP_PASSIVE, CCP_BUSOFF} ccp_state_e;
    typedef enum logic [1:0] {CCP_DISABLED, CCP_NORMAL, CCP_SLEEP, CCP_POWERDOWN} ccp_mode_e;

    typedef struct packed {
        logic        rxDone;
        logic        fifoOverflow;
        logic        fifoNext;
        logic [2:0]  txScheduled;
        ccp_state_e  txState;
        ccp_state_e  rxState;
        logic        protoBusOff;
    } ccp_core_s;
endpackage : ccp_pkg

// ==== rtl/ccp_ctrl.sv ====
// CAN controller mode, interrupt and bus-off recovery control
// assumes protocol core status synchronous to sys_clk; one clock domain
// Operation
// - reset leaves module disabled, registers reachable
// - wake-up enable wakes on bus activity
// - filter select suppresses short receive glitches
// - four maskable interrupt outputs
// - empty flag per unscheduled transmit buffer
// - receive-full set after end of frame
// - receive-full set again for next message
// - wake interrupt only from acknowledged sleep
// - receive overflow sets overrun flag
// - error range change sets status-change flag; here only a change into warning, passive or bus-off sets it
// - interrupt holds while any flag set
// - writing one clears flag, zero ignored
// - clear ignored while condition persists
// - auto bus-off recovery after 128x11 recessive
// - user mode also needs hold cleared
// - wait 11 recessive bits after wake-up
// - power-down on stop or waited stop
// - init acknowledge after all domains synced
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module ccp_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic                   wb_ack_o,
    input  wire ccp_pkg::ccp_core_s core,
    input  wire logic              cpuStop,
    input  wire logic              cpuWait,
    input  wire logic              busReceivePin,
    output logic                   busTransmitPin,
    output logic                   busRxEnable,
    output logic                   busOffRecover,
    output logic                   irqWake,
    output logic                   irqError,
    output logic                   irqReceive,
    output logic                   irqTransmit
);
    logic [7:0] ctrl0Reg, ctrl1Reg, rflgReg, rierReg, miscReg;
    logic [2:0] txeReg, tierReg;
    ccp_pkg::ccp_mode_e modeReg;
    logic [5:0] filtCnt;
    logic [1:0] initSync;
    logic [3:0] runBits;
    logic [7:0] runCount;
    logic       recDone;
    logic [5:0] bitTick;
    logic       syncWait;
    logic [3:0] syncBits;
    logic       ackReg;
    logic [31:0] datReg;
    ccp_pkg::ccp_state_e txStPrev, rxStPrev;

    wire access  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wrLow   = access && wb_we_i && wb_sel_i[0];
    wire enabled = ctrl1Reg[ccp_pkg::C1_ENABLE];
    wire isC0    = wb_adr_i == ccp_pkg::CTRL0_ADDR;
    wire isC1    = wb_adr_i == ccp_pkg::CTRL1_ADDR;
    wire isRf    = wb_adr_i == ccp_pkg::RFLG_ADDR;
    wire isRi    = wb_adr_i == ccp_pkg::RIER_ADDR;
    wire isTf    = wb_adr_i == ccp_pkg::TFLG_ADDR;
    wire isTi    = wb_adr_i == ccp_pkg::TIER_ADDR;
    wire isMi    = wb_adr_i == ccp_pkg::MISC_ADDR;
    wire [7:0] wd = wb_dat_i[7:0];
    // clocks of the core run only when enabled and awake
    wire running = modeReg == ccp_pkg::CCP_NORMAL;
    wire asleep  = modeReg == ccp_pkg::CCP_SLEEP || modeReg == ccp_pkg::CCP_POWERDOWN;
    wire pdReq   = enabled && (cpuStop || (cpuWait && ctrl0Reg[7]));
    // bus dominant is low
    wire rxActive = !busReceivePin;
    wire filtOn   = ctrl1Reg[ccp_pkg::C1_WFILT];
    wire wakeSeen = filtOn ? (filtCnt == 6'(ccp_pkg::WAKE_FILTER_CYC)) : rxActive;
    wire wakeEvt  = asleep && ctrl0Reg[ccp_pkg::C0_WUPEN] && wakeSeen;
    wire sleepOk  = ctrl0Reg[ccp_pkg::C0_SLEEP_REQUEST] && !core.rxDone && (txeReg == 3'h7);
    wire bitEn    = bitTick == 6'(ccp_pkg::BIT_CYC - 1);
    wire runEnd   = bitEn && busReceivePin && runBits == 4'(ccp_pkg::RECESSIVE_RUN - 1);
    wire busOff   = core.txState == ccp_pkg::CCP_BUSOFF;
    wire holdClr  = !miscReg[0];
    wire recover  = busOff && recDone &&
                    (!ctrl1Reg[ccp_pkg::C1_BORUM] || holdClr);
    wire cscEvt   = running && ((core.txState != txStPrev && core.txState != ccp_pkg::CCP_OK) ||
                    (core.rxState != rxStPrev && core.rxState != ccp_pkg::CCP_OK));
    wire rxfEvt   = running && (core.rxDone || core.fifoNext);
    wire ovrEvt   = running && core.fifoOverflow;
    // a wake flag may only arise from an acknowledged sleep
    wire wakeFlag = wakeEvt && ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] && rierReg[7];
    wire [7:0] rfClr = (wrLow && isRf) ? wd : 8'h00;
    wire [2:0] tfClr = (wrLow && isTf) ? wd[2:0] : 3'h0;
    wire [7:0] rdMux = isC0 ? ctrl0Reg : isC1 ? ctrl1Reg : isRf ? rflgReg :
                       isRi ? rierReg : isTf ? {5'h0, txeReg} : isTi ? {5'h0, tierReg} :
                       isMi ? miscReg : 8'h00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ackReg <= 1'b0;
            datReg <= 32'h0000_0000;
        end else begin
            ackReg <= access;
            datReg <= {24'h00_0000, rdMux};
        end
    end
    assign wb_ack_o = ackReg;
    assign wb_dat_o = datReg;

    // mode machine; registers stay reachable in every mode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            modeReg  <= ccp_pkg::CCP_DISABLED;
            ctrl0Reg <= ccp_pkg::CTRL0_RST;
            ctrl1Reg <= ccp_pkg::CTRL1_RST;
            miscReg  <= ccp_pkg::MISC_RST;
            rierReg  <= 8'h00;
            tierReg  <= 3'h0;
            // init request is high out of reset, so its chain starts full
            initSync <= 2'h3;
        end else begin
            if (wrLow && isC0) begin
                ctrl0Reg[7] <= wd[7];
                ctrl0Reg[ccp_pkg::C0_WUPEN] <= wd[ccp_pkg::C0_WUPEN];
                // request bits may not drop before their acknowledge
                if (wd[ccp_pkg::C0_SLEEP_REQUEST] || ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE])
                    ctrl0Reg[ccp_pkg::C0_SLEEP_REQUEST] <= wd[ccp_pkg::C0_SLEEP_REQUEST];
                if (wd[ccp_pkg::C0_INIRQ] || ctrl1Reg[ccp_pkg::C1_INIAK])
                    ctrl0Reg[ccp_pkg::C0_INIRQ] <= wd[ccp_pkg::C0_INIRQ];
            end else if (wakeEvt) begin
                ctrl0Reg[ccp_pkg::C0_SLEEP_REQUEST] <= 1'b0;
            end
            if (wrLow && isC1) begin
                ctrl1Reg[ccp_pkg::C1_ENABLE] <= wd[ccp_pkg::C1_ENABLE];
                if (ctrl1Reg[ccp_pkg::C1_INIAK]) begin
                    ctrl1Reg[ccp_pkg::C1_BORUM] <= wd[ccp_pkg::C1_BORUM];
                    ctrl1Reg[ccp_pkg::C1_WFILT] <= wd[ccp_pkg::C1_WFILT];
                end
            end
            if (wrLow && isRi) rierReg <= wd;
            if (wrLow && isTi) tierReg <= wd[2:0];
            // hold arms once on entry to bus-off, so an early release sticks
            if (busOff && txStPrev != ccp_pkg::CCP_BUSOFF && ctrl1Reg[ccp_pkg::C1_BORUM])
                miscReg[0] <= 1'b1;
            else if (wrLow && isMi) miscReg[0] <= wd[0];
            // init handshake crosses the protocol clock in a few stages
            initSync <= {initSync[0], ctrl0Reg[ccp_pkg::C0_INIRQ]};
            ctrl1Reg[ccp_pkg::C1_INIAK] <= ctrl0Reg[ccp_pkg::C0_INIRQ] && initSync[1];
            case (modeReg)
                ccp_pkg::CCP_DISABLED: if (enabled) modeReg <= ccp_pkg::CCP_NORMAL;
                ccp_pkg::CCP_NORMAL: begin
                    if (!enabled) modeReg <= ccp_pkg::CCP_DISABLED;
                    else if (pdReq) modeReg <= ccp_pkg::CCP_POWERDOWN;
                    else if (sleepOk) begin
                        modeReg <= ccp_pkg::CCP_SLEEP;
                        ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] <= 1'b1;
                    end
                end
                ccp_pkg::CCP_SLEEP: begin
                    if (!enabled) modeReg <= ccp_pkg::CCP_DISABLED;
                    else if (pdReq) modeReg <= ccp_pkg::CCP_POWERDOWN;
                    else if (wakeEvt || !ctrl0Reg[ccp_pkg::C0_SLEEP_REQUEST]) begin
                        modeReg <= ccp_pkg::CCP_NORMAL;
                        ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] <= 1'b0;
                    end
                end
                default: begin
                    if (!enabled) modeReg <= ccp_pkg::CCP_DISABLED;
                    else if (!pdReq || wakeEvt) begin
                        modeReg <= ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] && !wakeEvt
                                   ? ccp_pkg::CCP_SLEEP : ccp_pkg::CCP_NORMAL;
                        if (wakeEvt) ctrl1Reg[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] <= 1'b0;
                    end
                end
            endcase
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rflgReg  <= 8'h00;
            txeReg   <= ccp_pkg::TXE_RST;
            txStPrev <= ccp_pkg::CCP_OK;
            rxStPrev <= ccp_pkg::CCP_OK;
        end else begin
            txStPrev <= core.txState;
            rxStPrev <= core.rxState;
            rflgReg[ccp_pkg::RF_WAKE] <= wakeFlag || (rflgReg[ccp_pkg::RF_WAKE] && !rfClr[ccp_pkg::RF_WAKE]);
            rflgReg[ccp_pkg::RF_CSC]  <= cscEvt || (rflgReg[ccp_pkg::RF_CSC] && !rfClr[ccp_pkg::RF_CSC]);
            rflgReg[ccp_pkg::RF_OVR]  <= ovrEvt || (rflgReg[ccp_pkg::RF_OVR] && !rfClr[ccp_pkg::RF_OVR]);
            rflgReg[ccp_pkg::RF_RXF]  <= rxfEvt || (rflgReg[ccp_pkg::RF_RXF] && !rfClr[ccp_pkg::RF_RXF]);
            rflgReg[ccp_pkg::RF_RST+1:ccp_pkg::RF_RST] <= core.rxState;
            rflgReg[ccp_pkg::RF_TST+1:ccp_pkg::RF_TST] <= core.txState;
            // empty flag cannot clear while buffer remains unscheduled
            txeReg <= (~core.txScheduled) | (txeReg & ~tfClr);
        end
    end

    // glitch filter, recessive run counter and resync
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            filtCnt  <= 6'h00;
            bitTick  <= 6'h00;
            runBits  <= 4'h0;
            runCount <= 8'h00;
            recDone  <= 1'b0;
            syncWait <= 1'b0;
            syncBits <= 4'h0;
        end else begin
            if (!rxActive) filtCnt <= 6'h00;
            else if (filtCnt != 6'(ccp_pkg::WAKE_FILTER_CYC)) filtCnt <= filtCnt + 6'h01;
            bitTick <= bitEn ? 6'h00 : bitTick + 6'h01;
            // counting stops with the clocks in sleep
            if (!running || !busOff) begin
                runBits <= 4'h0;
                if (!busOff) begin
                    runCount <= 8'h00;
                    recDone  <= 1'b0;
                end
            end else if (bitEn) begin
                if (!busReceivePin || runEnd) runBits <= 4'h0;
                else runBits <= runBits + 4'h1;
                if (runEnd && !recDone) begin
                    runCount <= runCount + 8'h01;
                    if (runCount == 8'(ccp_pkg::RECOVERY_RUNS - 1)) recDone <= 1'b1;
                end
            end
            if (wakeEvt) begin
                syncWait <= 1'b1;
                syncBits <= 4'h0;
            end else if (syncWait && bitEn) begin
                if (!busReceivePin) syncBits <= 4'h0;
                else if (syncBits == 4'(ccp_pkg::RECESSIVE_RUN - 1)) syncWait <= 1'b0;
                else syncBits <= syncBits + 4'h1;
            end
        end
    end

    // outputs registered; interrupts follow flags and enables
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busTransmitPin <= 1'b1;
            busRxEnable    <= 1'b0;
            busOffRecover  <= 1'b0;
            irqWake        <= 1'b0;
            irqError       <= 1'b0;
            irqReceive     <= 1'b0;
            irqTransmit    <= 1'b0;
        end else begin
            busTransmitPin <= 1'b1;
            busRxEnable    <= running && !syncWait && !pdReq;
            busOffRecover  <= recover;
            irqWake    <= rflgReg[ccp_pkg::RF_WAKE] && rierReg[7];
            irqError   <= (rflgReg[ccp_pkg::RF_CSC] && rierReg[6]) ||
                          (rflgReg[ccp_pkg::RF_OVR] && rierReg[1]);
            irqReceive <= rflgReg[ccp_pkg::RF_RXF] && rierReg[0];
            irqTransmit <= |(txeReg & tierReg);
        end
    end
endmodule : ccp_ctrl

// ==== bench/ccp_bus_node.sv ====
// bus node seen through the transceiver, driving the receive pin
// assumes the bench calls it just after a rising sys_clk edge
`timescale 1ns/1ps
module ccp_bus_node (
    input  wire logic sysClk,
    output logic      rxLine
);
    // idle bus rests recessive, which also feeds the recessive-run counting
    initial rxLine = 1'h1;

    task automatic dominant(input int cycles);
        rxLine <= 1'h0;
        repeat (cycles) @(posedge sysClk);
        rxLine <= 1'h1;
    endtask : dominant
endmodule : ccp_bus_node

// ==== bench/ccp_ctrl_chk.sv ====
// checker for ccp_ctrl: bus handshake and flag to interrupt timing
// assumes it is bound to ccp_ctrl; enable bits are snooped from bus writes
`timescale 1ns/1ps
module ccp_ctrl_chk (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic               wb_we_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire ccp_pkg::ccp_core_s core,
    input wire logic               busTransmitPin,
    input wire logic               busRxEnable,
    input wire logic               busOffRecover,
    input wire logic               irqWake,
    input wire logic               irqError,
    input wire logic               irqReceive
);
    logic [7:0] rier_reg;
    logic [7:0] ctrl0_reg;
    logic [2:0] wrHist_reg;
    wire        wrDone = wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rier_reg   <= 8'h00;
            ctrl0_reg  <= ccp_pkg::CTRL0_RST;
            wrHist_reg <= 3'h0;
        end else begin
            if (wrDone && wb_adr_i == ccp_pkg::RIER_ADDR) rier_reg <= wb_dat_i[7:0];
            if (wrDone && wb_adr_i == ccp_pkg::CTRL0_ADDR) ctrl0_reg <= wb_dat_i[7:0];
            // a clear may land on the taken edge or the ack edge
            wrHist_reg <= {wrHist_reg[1:0], wb_cyc_i && wb_we_i};
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for a second cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_tx_recessive: assert property (busTransmitPin)
        else $error("transmit pin not recessive");
    a_rx_irq_set: assert property (core.rxDone && rier_reg[0] |-> ##2 irqReceive)
        else $error("receive interrupt missing after frame");
    a_next_irq_set: assert property (core.fifoNext && rier_reg[0] |-> ##2 irqReceive)
        else $error("receive interrupt missing for next message");
    a_ovr_irq_set: assert property (core.fifoOverflow && rier_reg[1] |-> ##2 irqError)
        else $error("error interrupt missing on overrun");
    a_csc_irq_set: assert property ($changed(core.txState) &&
        core.txState != ccp_pkg::CCP_OK && rier_reg[6] |-> ##[2:3] irqError)
        else $error("error interrupt missing on state change");
    a_irq_hold: assert property ($fell(irqReceive) |-> wrHist_reg != 3'h0)
        else $error("receive interrupt dropped without a write");
    a_wake_cause: assert property ($rose(irqWake) |->
        rier_reg[7] && ctrl0_reg[ccp_pkg::C0_WUPEN])
        else $error("wake interrupt without its enables");
    a_wake_resync: assert property ($rose(irqWake) |-> !busRxEnable [*8])
        else $error("receiver joined the bus right after wake");

    c_rx_irq: cover property (core.rxDone && rier_reg[0]);
    c_wake: cover property ($rose(irqWake));
    c_recover: cover property ($rose(busOffRecover));
endmodule : ccp_ctrl_chk

bind ccp_ctrl ccp_ctrl_chk u_chk (
    .sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .core(core), .busTransmitPin(busTransmitPin),
    .busRxEnable(busRxEnable), .busOffRecover(busOffRecover), .irqWake(irqWake),
    .irqError(irqError), .irqReceive(irqReceive));

// ==== bench/testbench.sv ====
// self-checking bench for ccp_ctrl, one task per scenario
// assumes the checker is bound in and a bus node drives the receive pin
`timescale 1ns/1ps
module testbench;
    logic               sysClk = 1'h0;
    logic               rst    = 1'h1;
    logic [7:0]         wbAdr  = 8'h00;
    logic [31:0]        wbDatI = 32'h0000_0000;
    logic [31:0]        wbDatO;
    logic               wbWe   = 1'h0;
    logic               wbCyc  = 1'h0;
    logic               wbStb  = 1'h0;
    logic               wbAck;
    ccp_pkg::ccp_core_s coreIn = '0;
    logic               rxLine;
    logic               cpuStop = 1'h0;
    logic               cpuWait = 1'h0;
    logic               txPin;
    logic               rxEn;
    logic               recover;
    logic [3:0]         irq;
    logic [7:0]         q;
    int                 num_errors  = 0;
    int                 comparisons = 0;
    int                 cycles      = 0;

    ccp_ctrl DUT (.sys_clk(sysClk), .rst(rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(4'h1), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_ack_o(wbAck), .core(coreIn), .cpuStop(cpuStop),
        .cpuWait(cpuWait), .busReceivePin(rxLine), .busTransmitPin(txPin),
        .busRxEnable(rxEn), .busOffRecover(recover), .irqWake(irq[3]),
        .irqError(irq[2]), .irqReceive(irq[1]), .irqTransmit(irq[0]));
    ccp_bus_node node (.sysClk(sysClk), .rxLine(rxLine));

    always #12.5 sysClk = ~sysClk;

    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // bus-off recovery alone needs about 56000 cycles
    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            finish_test;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic xfer(input logic [7:0] adr, input logic we, input logic [7:0] dat);
        int n;
        wbAdr  <= adr;
        wbWe   <= we;
        wbDatI <= {24'h00_0000, dat};
        wbCyc  <= 1'h1;
        wbStb  <= 1'h1;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (wbAck !== 1'h1 && n < 100);
        if (n == 100) num_errors++;
        q = wbDatO[7:0];
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        @(posedge sysClk);
    endtask : xfer

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        xfer(adr, 1'h1, dat);
    endtask : wr

    task automatic rd(input logic [7:0] adr);
        xfer(adr, 1'h0, 8'h00);
    endtask : rd

    task automatic pulse(input logic [2:0] m);
        {coreIn.rxDone, coreIn.fifoOverflow, coreIn.fifoNext} <= m;
        @(posedge sysClk);
        {coreIn.rxDone, coreIn.fifoOverflow, coreIn.fifoNext} <= 3'h0;
        repeat (2) @(posedge sysClk);
    endtask : pulse

    task automatic tResetStart;
        rd(ccp_pkg::CTRL0_ADDR);
        check(q, ccp_pkg::CTRL0_RST);
        rd(ccp_pkg::CTRL1_ADDR);
        check(q, ccp_pkg::CTRL1_RST);
        rd(ccp_pkg::TFLG_ADDR);
        check(q, {5'h00, ccp_pkg::TXE_RST});
        rd(8'h20);
        check(q, 8'h00);
        check({3'h0, txPin, irq}, 8'h10);
        wr(ccp_pkg::CTRL1_ADDR, 8'h84);
        wr(ccp_pkg::CTRL0_ADDR, 8'h04);
        repeat (3) @(posedge sysClk);
        rd(ccp_pkg::CTRL1_ADDR);
        check(q, 8'h84);
    endtask : tResetStart

    task automatic tTransmit;
        wr(ccp_pkg::TIER_ADDR, 8'h01);
        coreIn.txScheduled <= 3'h6;
        repeat (3) @(posedge sysClk);
        check({4'h0, irq}, 8'h01);
        wr(ccp_pkg::TFLG_ADDR, 8'h01);
        rd(ccp_pkg::TFLG_ADDR);
        check(q, 8'h07);
        coreIn.txScheduled <= 3'h7;
        wr(ccp_pkg::TFLG_ADDR, 8'h01);
        rd(ccp_pkg::TFLG_ADDR);
        check(q, 8'h06);
        check({4'h0, irq}, 8'h00);
        coreIn.txScheduled <= 3'h0;
        wr(ccp_pkg::TIER_ADDR, 8'h00);
        @(posedge sysClk);
        check({4'h0, irq}, 8'h00);
    endtask : tTransmit

    task automatic tReceive;
        wr(ccp_pkg::RIER_ADDR, 8'h03);
        pulse(3'h4);
        check({4'h0, irq}, 8'h02);
        wr(ccp_pkg::RFLG_ADDR, 8'h00);
        rd(ccp_pkg::RFLG_ADDR);
        check(q, 8'h01);
        wr(ccp_pkg::RFLG_ADDR, 8'h01);
        @(posedge sysClk);
        check({4'h0, irq}, 8'h00);
        pulse(3'h1);
        check({4'h0, irq}, 8'h02);
        wr(ccp_pkg::RFLG_ADDR, 8'h01);
        pulse(3'h2);
        check({4'h0, irq}, 8'h04);
        rd(ccp_pkg::RFLG_ADDR);
        check(q, 8'h02);
        wr(ccp_pkg::RFLG_ADDR, 8'h02);
    endtask : tReceive

    task automatic tStatus;
        wr(ccp_pkg::RIER_ADDR, 8'h40);
        coreIn.txState <= ccp_pkg::CCP_WARN;
        coreIn.rxState <= ccp_pkg::CCP_PASSIVE;
        repeat (4) @(posedge sysClk);
        check({4'h0, irq}, 8'h04);
        rd(ccp_pkg::RFLG_ADDR);
        check(q, 8'h64);
        coreIn.txState <= ccp_pkg::CCP_OK;
        coreIn.rxState <= ccp_pkg::CCP_OK;
        wr(ccp_pkg::RFLG_ADDR, 8'h40);
        @(posedge sysClk);
        check({4'h0, irq}, 8'h00);
    endtask : tStatus

    task automatic tWakeBusOff;
        int n;
        wr(ccp_pkg::RIER_ADDR, 8'h80);
        wr(ccp_pkg::CTRL0_ADDR, 8'h06);
        n = 0;
        do begin
            rd(ccp_pkg::CTRL1_ADDR);
            n++;
        end while (q[ccp_pkg::C1_SLEEP_ACKNOWLEDGE] !== 1'h1 && n < 50);
        check(q, 8'h86);
        node.dominant(5);
        repeat (4) @(posedge sysClk);
        check({4'h0, irq}, 8'h00);
        node.dominant(2 * ccp_pkg::WAKE_FILTER_CYC);
        repeat (4) @(posedge sysClk);
        check({3'h0, rxEn, irq}, 8'h08);
        wr(ccp_pkg::RFLG_ADDR, 8'h80);
        // second write covers a sleep request that was refused mid-wake
        repeat (2) begin
            wr(ccp_pkg::CTRL0_ADDR, 8'h04);
            n = 0;
            while (rxEn !== 1'h1 && n < 1000) begin
                @(posedge sysClk);
                n++;
            end
        end
        check({3'h0, rxEn, irq}, 8'h10);
        coreIn.txState <= ccp_pkg::CCP_BUSOFF;
        n = 0;
        while (recover !== 1'h1 && n < 70000) begin
            @(posedge sysClk);
            n++;
        end
        check({7'h00, recover}, 8'h01);
        check({6'h00,
            n >= (ccp_pkg::RECOVERY_RUNS * ccp_pkg::RECESSIVE_RUN - 1) * ccp_pkg::BIT_CYC,
            n <= ccp_pkg::RECOVERY_RUNS * ccp_pkg::RECESSIVE_RUN * ccp_pkg::BIT_CYC + 3},
            8'h03);
    endtask : tWakeBusOff

    task automatic tPowerDown;
        cpuStop <= 1'h1;
        repeat (3) @(posedge sysClk);
        check({2'h0, txPin, rxEn, irq}, 8'h20);
        cpuStop <= 1'h0;
        cpuWait <= 1'h1;
        repeat (3) @(posedge sysClk);
        check({2'h0, txPin, rxEn, irq}, 8'h30);
        wr(ccp_pkg::CTRL0_ADDR, 8'h84);
        repeat (2) @(posedge sysClk);
        check({2'h0, txPin, rxEn, irq}, 8'h20);
        cpuWait <= 1'h0;
        repeat (3) @(posedge sysClk);
        check({2'h0, txPin, rxEn, irq}, 8'h30);
    endtask : tPowerDown

    task automatic tHoldRelease;
        coreIn.txState <= ccp_pkg::CCP_OK;
        wr(ccp_pkg::CTRL0_ADDR, 8'h06);
        rd(ccp_pkg::CTRL1_ADDR);
        check(q, 8'h86);
        wr(ccp_pkg::CTRL0_ADDR, 8'h07);
        repeat (3) @(posedge sysClk);
        rd(ccp_pkg::CTRL1_ADDR);
        check(q, 8'h87);
        wr(ccp_pkg::CTRL1_ADDR, 8'h8C);
        wr(ccp_pkg::CTRL0_ADDR, 8'h04);
        rd(ccp_pkg::CTRL1_ADDR);
        check(q, 8'h8C);
        coreIn.txState <= ccp_pkg::CCP_BUSOFF;
        repeat (2) @(posedge sysClk);
        rd(ccp_pkg::MISC_ADDR);
        check(q, 8'h01);
        wr(ccp_pkg::MISC_ADDR, 8'h00);
        repeat (2) @(posedge sysClk);
        rd(ccp_pkg::MISC_ADDR);
        check(q, 8'h00);
        check({7'h00, recover}, 8'h00);
    endtask : tHoldRelease

    initial begin
        repeat (4) @(posedge sysClk);
        rst <= 1'h0;
        tResetStart;
        tTransmit;
        tReceive;
        tStatus;
        tPowerDown;
        tWakeBusOff;
        tHoldRelease;
        finish_test;
    end
endmodule : testbench
